// File: pad_common_status.v
// pad snapshot, common status and extra fault state registers
`timescale 1ns/1ps
`include "pad_status_map.vh"

// Notes on behaviour
// - pad snapshot shows synchronised raw pin levels, no deglitch filter
// - bit 15 reads 0 while we pull power-good low
// - bit 14 reads 0 while we pull alert low
// - bits 13:12 show our pull on fault bus lines zero and one
// - bits 11:10 show our pull on channel-good one and zero
// - bits 9:8 encode second address pin: high 11, float 10, low 00
// - bits 7:6 encode first address pin the same way
// - bits 5 and 4 show on/off pins one and zero
// - bits 3:2 show sensed fault bus lines zero and one
// - bits 1 and 0 show sensed channel-good one and zero
// - common status stays readable while the device is busy
// - when busy, refuse other commands and set the busy status flag
// - common bit 7 is 1 when alert is released, 0 when pulled
// - common bit 6 is 1 when ready, 0 when busy
// - common bits 5:2 always read ones
// - common bit 1 is 1 while share clock is held low
// - common bit 0 mirrors the write-protect pin
// - extra status bits 15:3 always read zero
// - short-cycle flag per page, set on early on, pulls alert low
// - sticky flags hold until fault clear or channel turned on
// - extra bit 1 shared by pages, shows our aux fault pull
// - extra bit 0 per page, set on input-voltage-off shutdown
module pad_common_status (
    // clock and reset
    input wire I_REF_CLK,
    input wire I_RST_N,
    // command port from the serial front end
    input wire I_CMD_VALID,
    input wire [7:0] I_CMD_CODE,
    input wire I_PAGE,
    input wire I_CLEAR_FAULTS,
    input wire I_BUSY,
    // command answer
    output wire O_RSP_VALID,
    output wire O_RSP_HIT,
    output wire O_RSP_NACK,
    output wire [15:0] O_RSP_DATA,
    output wire O_BUSY_FLAG,
    // raw pin levels
    input wire [1:0] I_FAULT_BUS_LINE,
    input wire [1:0] I_CHAN_GOOD,
    input wire [1:0] I_ON_OFF_PIN,
    input wire [1:0] I_ADDR_SELECT_ZERO,
    input wire [1:0] I_ADDR_SELECT_ONE,
    input wire I_SHARE_CLK,
    input wire I_WRITE_PROTECT,
    input wire I_ALERT_PIN,
    // pull-down requests from internal logic
    input wire I_PWRGD_PULL,
    input wire [1:0] I_FAULT_BUS_PULL,
    input wire [1:0] I_CHAN_GOOD_PULL,
    input wire I_AUX_FAULT_PULL,
    input wire I_ALERT_REQ,
    // channel events from the sequencer
    input wire [1:0] I_CHAN_ON_CMD,
    input wire [1:0] I_OFF_IN_PROGRESS,
    input wire [1:0] I_VIN_OFF_EVT,
    // alert pad, open drain
    output wire O_ALERT_O,
    output wire O_ALERT_OE
);
    ////////////////////////////////////////////////////////////////////////
    // reset release
    reg rst_meta_r;
    reg rst_sync_r;
    wire rst_n;
    always @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire [1:0] fault_lvl;
    wire [1:0] good_lvl;
    wire [1:0] onoff_lvl;
    wire [1:0] addr_select_zero_lvl;
    wire [1:0] addr_select_one_lvl;
    wire share_lvl;
    wire wp_lvl;
    wire alert_lvl;

    // raw levels only: the snapshot bypasses any deglitch filter
    pin_sync #(.W(2)) u_fault_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_FAULT_BUS_LINE),
        .o_lvl(fault_lvl)
    );

    pin_sync #(.W(2)) u_good_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_CHAN_GOOD),
        .o_lvl(good_lvl)
    );

    pin_sync #(.W(2)) u_onoff_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_ON_OFF_PIN),
        .o_lvl(onoff_lvl)
    );

    pin_sync #(.W(2)) u_addr_zero_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_ADDR_SELECT_ZERO),
        .o_lvl(addr_select_zero_lvl)
    );

    pin_sync #(.W(2)) u_addr_one_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_ADDR_SELECT_ONE),
        .o_lvl(addr_select_one_lvl)
    );

    pin_sync #(.W(1)) u_share_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_SHARE_CLK),
        .o_lvl(share_lvl)
    );

    pin_sync #(.W(1)) u_wp_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_WRITE_PROTECT),
        .o_lvl(wp_lvl)
    );

    pin_sync #(.W(1)) u_alert_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_ALERT_PIN),
        .o_lvl(alert_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // address select encoding; input [1] = float sense, [0] = level
    function [1:0] asel_code;
        input [1:0] sense;
        begin
            if (sense[1])
                asel_code = `ASEL_FLOAT;
            else if (sense[0])
                asel_code = `ASEL_HIGH;
            else
                asel_code = `ASEL_LOW;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // share clock activity: held low once no edge seen for the idle time
    reg share_prev_r;
    reg [`SHARE_CNT_W-1:0] share_cnt_r;
    reg [`SHARE_CNT_W-1:0] share_cnt_nxt;
    reg share_held_low_r;
    wire share_edge;
    localparam integer SHARE_IDLE_INT = `SHARE_IDLE_CYC;
    localparam [`SHARE_CNT_W-1:0] SHARE_IDLE =
        SHARE_IDLE_INT[`SHARE_CNT_W-1:0];
    assign share_edge = share_lvl ^ share_prev_r;
    always @* begin
        if (share_edge)
            share_cnt_nxt = {`SHARE_CNT_W{1'b0}};
        else if (share_cnt_r != SHARE_IDLE)
            share_cnt_nxt = share_cnt_r + 1'b1;
        else
            share_cnt_nxt = share_cnt_r;
    end
    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            share_prev_r <= 1'b0;
            share_cnt_r <= {`SHARE_CNT_W{1'b0}};
            share_held_low_r <= 1'b0;
        end else begin
            share_prev_r <= share_lvl;
            share_cnt_r <= share_cnt_nxt;
            share_held_low_r <= ~share_lvl &
                (share_cnt_nxt == SHARE_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel sticky flags
    wire [1:0] short_cycle;
    wire [1:0] vin_caused_off;
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_chan
            chan_sticky u_sticky (
                .i_clk(I_REF_CLK),
                .i_rst_n(rst_n),
                .i_clear_faults(I_CLEAR_FAULTS),
                .i_on_cmd(I_CHAN_ON_CMD[c]),
                .i_off_in_progress(I_OFF_IN_PROGRESS[c]),
                .i_vin_off_evt(I_VIN_OFF_EVT[c]),
                .o_short_cycle(short_cycle[c]),
                .o_vin_caused_off(vin_caused_off[c])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // alert drive
    reg alert_pull_r;
    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n)
            alert_pull_r <= 1'b0;
        else
            alert_pull_r <= I_ALERT_REQ | (|short_cycle);
    end
    assign O_ALERT_O = 1'b0;
    assign O_ALERT_OE = alert_pull_r;

    ////////////////////////////////////////////////////////////////////////
    // register images
    reg [15:0] pad_level_snapshot_r;
    reg [7:0] device_common_status_r;
    wire [15:0] extra_fault_state_status;
    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pad_level_snapshot_r <= `PAD_RESET;
        end else begin
            pad_level_snapshot_r[`PAD_PWRGD_DRV_BIT] <= ~I_PWRGD_PULL;
            pad_level_snapshot_r[`PAD_ALERT_DRV_BIT] <= ~alert_pull_r;
            pad_level_snapshot_r[`PAD_FAULT_DRV_HI:`PAD_FAULT_DRV_LO] <=
                ~{I_FAULT_BUS_PULL[0], I_FAULT_BUS_PULL[1]};
            pad_level_snapshot_r[`PAD_GOOD_DRV_HI:`PAD_GOOD_DRV_LO] <=
                ~{I_CHAN_GOOD_PULL[1], I_CHAN_GOOD_PULL[0]};
            pad_level_snapshot_r[`PAD_ADDR_ONE_HI:`PAD_ADDR_ONE_LO] <=
                asel_code(addr_select_one_lvl);
            pad_level_snapshot_r[`PAD_ADDR_ZERO_HI:`PAD_ADDR_ZERO_LO] <=
                asel_code(addr_select_zero_lvl);
            pad_level_snapshot_r[`PAD_ONOFF1_BIT] <= onoff_lvl[1];
            pad_level_snapshot_r[`PAD_ONOFF0_BIT] <= onoff_lvl[0];
            pad_level_snapshot_r[`PAD_FAULT_LVL_HI:`PAD_FAULT_LVL_LO] <=
                {fault_lvl[0], fault_lvl[1]};
            pad_level_snapshot_r[`PAD_GOOD1_BIT] <= good_lvl[1];
            pad_level_snapshot_r[`PAD_GOOD0_BIT] <= good_lvl[0];
        end
    end

    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            device_common_status_r <= `COM_RESET;
        end else begin
            device_common_status_r[`COM_ALERT_BIT] <= alert_lvl;
            device_common_status_r[`COM_READY_BIT] <= ~I_BUSY;
            device_common_status_r[5:2] <= `COM_RSVD_ONES;
            device_common_status_r[`COM_SHARE_BIT] <= share_held_low_r;
            device_common_status_r[`COM_WP_BIT] <= wp_lvl;
        end
    end
    assign extra_fault_state_status = {`EXT_RSVD_ZERO,
        short_cycle[I_PAGE],
        I_AUX_FAULT_PULL,
        vin_caused_off[I_PAGE]};

    ////////////////////////////////////////////////////////////////////////
    // command answer
    reg rsp_valid_r;
    reg rsp_hit_r;
    reg rsp_nack_r;
    reg [15:0] rsp_data_r;
    reg [15:0] rsp_data_nxt;
    reg rsp_hit_nxt;
    reg busy_flag_r;
    wire is_common;
    wire refuse;
    assign is_common = (I_CMD_CODE == `CMD_DEVICE_COMMON_STATUS);
    assign refuse = I_CMD_VALID & I_BUSY & ~is_common;

    function cmd_hit;
        input [7:0] code;
        begin
            case (code)
                `CMD_PAD_LEVEL_SNAPSHOT: cmd_hit = 1'b1;
                `CMD_DEVICE_COMMON_STATUS: cmd_hit = 1'b1;
                `CMD_EXTRA_FAULT_STATE_STATUS: cmd_hit = 1'b1;
                default: cmd_hit = 1'b0;
            endcase
        end
    endfunction

    always @* begin
        rsp_hit_nxt = cmd_hit(I_CMD_CODE);
        case (I_CMD_CODE)
            `CMD_PAD_LEVEL_SNAPSHOT:
                rsp_data_nxt = pad_level_snapshot_r;
            `CMD_DEVICE_COMMON_STATUS:
                rsp_data_nxt = {8'h00, device_common_status_r};
            `CMD_EXTRA_FAULT_STATE_STATUS:
                rsp_data_nxt = extra_fault_state_status;
            default: rsp_data_nxt = 16'h0000;
        endcase
        if (refuse) begin
            rsp_data_nxt = 16'h0000;
        end
    end

    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_hit_r <= 1'b0;
            rsp_nack_r <= 1'b0;
            rsp_data_r <= 16'h0000;
        end else begin
            rsp_valid_r <= I_CMD_VALID;
            if (I_CMD_VALID) begin
                rsp_hit_r <= rsp_hit_nxt;
                rsp_nack_r <= refuse;
                rsp_data_r <= rsp_data_nxt;
            end
        end
    end

    // sticky busy flag; set wins over a clear in the same cycle
    always @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            busy_flag_r <= 1'b0;
        end else if (refuse) begin
            busy_flag_r <= 1'b1;
        end else if (I_CLEAR_FAULTS) begin
            busy_flag_r <= 1'b0;
        end
    end
    assign O_RSP_VALID = rsp_valid_r;
    assign O_RSP_HIT = rsp_hit_r;
    assign O_RSP_NACK = rsp_nack_r;
    assign O_RSP_DATA = rsp_data_r;
    assign O_BUSY_FLAG = busy_flag_r;
endmodule

// File: pad_status_map.vh
// constants for the pad snapshot and common status registers
`ifndef PAD_STATUS_MAP_VH
`define PAD_STATUS_MAP_VH

// command codes answered by this block (values are arbitrary)
`define CMD_PAD_LEVEL_SNAPSHOT 8'hE0
`define CMD_DEVICE_COMMON_STATUS 8'hE1
`define CMD_EXTRA_FAULT_STATE_STATUS 8'hE2

// pad snapshot field positions
`define PAD_PWRGD_DRV_BIT 15
`define PAD_ALERT_DRV_BIT 14
`define PAD_FAULT_DRV_HI 13
`define PAD_FAULT_DRV_LO 12
`define PAD_GOOD_DRV_HI 11
`define PAD_GOOD_DRV_LO 10
`define PAD_ADDR_ONE_HI 9
`define PAD_ADDR_ONE_LO 8
`define PAD_ADDR_ZERO_HI 7
`define PAD_ADDR_ZERO_LO 6
`define PAD_ONOFF1_BIT 5
`define PAD_ONOFF0_BIT 4
`define PAD_FAULT_LVL_HI 3
`define PAD_FAULT_LVL_LO 2
`define PAD_GOOD1_BIT 1
`define PAD_GOOD0_BIT 0

// address select encodings
`define ASEL_HIGH 2'h3
`define ASEL_FLOAT 2'h2
`define ASEL_LOW 2'h0

// common status fields
`define COM_ALERT_BIT 7
`define COM_READY_BIT 6
`define COM_RSVD_ONES 4'hF
`define COM_SHARE_BIT 1
`define COM_WP_BIT 0

// extra status fields
`define EXT_SHORTCYCLE_BIT 2
`define EXT_AUX_DRV_BIT 1
`define EXT_VIN_OFF_BIT 0
`define EXT_RSVD_ZERO 13'h0_000

// register image reset values
`define PAD_RESET 16'hFFFF
`define COM_RESET 8'hFF

// share clock idle detection: least time with no edge before "held low"
`define CLK_MHZ 200
`define SHARE_IDLE_NS 10000
`define SHARE_IDLE_CYC ((`SHARE_IDLE_NS * `CLK_MHZ + 999) / 1000)
`define SHARE_CNT_W 12

`endif

// File: pin_sync.v
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // pins
    input wire [W-1:0] i_pin,
    output wire [W-1:0] o_lvl
);
    reg [W-1:0] meta_r;
    reg [W-1:0] lvl_r;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta_r[g] <= 1'b0;
                    lvl_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= i_pin[g];
                    lvl_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate
    assign o_lvl = lvl_r;
endmodule

// File: chan_sticky.v
// per-channel sticky fault flags
`timescale 1ns/1ps
module chan_sticky (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // events and clears
    input wire i_clear_faults,
    input wire i_on_cmd,
    input wire i_off_in_progress,
    input wire i_vin_off_evt,
    // flags
    output wire o_short_cycle,
    output wire o_vin_caused_off
);
    reg short_r;
    reg vin_off_r;
    wire short_set;
    wire turned_on;
    assign short_set = i_on_cmd & i_off_in_progress;
    assign turned_on = i_on_cmd & ~i_off_in_progress;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            short_r <= 1'b0;
            vin_off_r <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            if (short_set)
                short_r <= 1'b1;
            else if (i_clear_faults | turned_on)
                short_r <= 1'b0;
            if (i_vin_off_evt)
                vin_off_r <= 1'b1;
            else if (i_clear_faults | i_on_cmd)
                vin_off_r <= 1'b0;
        end
    end
    assign o_short_cycle = short_r;
    assign o_vin_caused_off = vin_off_r;
endmodule

// File: pad_common_status_monitor.sv
// assertions on the ports of the pad and common status register block
`timescale 1ns/1ps
`include "pad_status_map.vh"
module pad_common_status_monitor (
    input wire I_REF_CLK,
    input wire I_RST_N,
    input wire I_CMD_VALID,
    input wire [7:0] I_CMD_CODE,
    input wire I_BUSY,
    input wire [1:0] I_CHAN_ON_CMD,
    input wire [1:0] I_OFF_IN_PROGRESS,
    input wire O_RSP_VALID,
    input wire O_RSP_HIT,
    input wire O_RSP_NACK,
    input wire [15:0] O_RSP_DATA,
    input wire O_BUSY_FLAG,
    input wire O_ALERT_OE,
    input wire O_ALERT_O
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    wire com = I_CMD_VALID && I_CMD_CODE == `CMD_DEVICE_COMMON_STATUS;
    wire ext = I_CMD_VALID && I_CMD_CODE == `CMD_EXTRA_FAULT_STATE_STATUS;
    wire refuse = I_CMD_VALID && I_BUSY && !com;
    wire known = I_CMD_CODE == `CMD_PAD_LEVEL_SNAPSHOT ||
        I_CMD_CODE == `CMD_DEVICE_COMMON_STATUS ||
        I_CMD_CODE == `CMD_EXTRA_FAULT_STATE_STATUS;
    a_rsp_after_cmd: assert property (I_CMD_VALID |=> O_RSP_VALID)
        else $error("no answer one cycle after a command");
    a_rsp_needs_cmd: assert property (O_RSP_VALID |-> $past(I_CMD_VALID))
        else $error("answer without a command");
    a_busy_refuse: assert property (refuse |=> O_RSP_NACK && !(|O_RSP_DATA))
        else $error("busy command not refused");
    a_busy_flag_set: assert property (refuse |-> ##[1:2] O_BUSY_FLAG)
        else $error("busy flag not set after refusal");
    a_common_open: assert property (com |=> !O_RSP_NACK &&
        O_RSP_DATA[15:8] == 8'h00 && O_RSP_DATA[5:2] == 4'hF)
        else $error("common status refused or reserved bits wrong");
    a_common_ready: assert property (com |=>
        O_RSP_DATA[6] == !$past(I_BUSY, 2))
        else $error("ready bit does not follow busy");
    a_extra_zero: assert property (ext && !I_BUSY |=> !(|O_RSP_DATA[15:3]))
        else $error("extra status reserved bits not zero");
    a_short_alert: assert property ((|(I_CHAN_ON_CMD & I_OFF_IN_PROGRESS))
        |-> ##[1:3] O_ALERT_OE)
        else $error("short cycle did not pull alert");
    a_hit_decode: assert property (I_CMD_VALID |=>
        O_RSP_HIT == $past(known))
        else $error("command hit flag does not match the code");
    a_alert_data: assert property (O_ALERT_O == 1'b0)
        else $error("alert data not held low");
endmodule
bind pad_common_status pad_common_status_monitor i_pad_common_status_monitor (
    .I_REF_CLK, .I_RST_N, .I_CMD_VALID, .I_CMD_CODE, .I_BUSY, .I_CHAN_ON_CMD,
    .I_OFF_IN_PROGRESS, .O_RSP_VALID, .O_RSP_HIT, .O_RSP_NACK, .O_RSP_DATA,
    .O_BUSY_FLAG, .O_ALERT_OE, .O_ALERT_O);

// File: smbus_host_model.sv
// host side model that issues status read command bytes
`timescale 1ns/1ps
module smbus_host_model (
    input wire i_clk,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_code,
    output logic o_page
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_code = 8'h00;
        o_page = 1'b0;
    end
    // polling the common status while busy is legal
    task automatic read_cmd(input logic [7:0] code, input logic pg);
        @(negedge i_clk);
        o_cmd_valid = 1'b1;
        o_cmd_code = code;
        o_page = pg;
        @(negedge i_clk);
        o_cmd_valid = 1'b0;
        o_cmd_code = ~code;
    endtask
endmodule

// File: tb_pad_common_status.sv
// testbench for the pad, common and extra status registers
`timescale 1ns/1ps
`include "pad_status_map.vh"
module tb_pad_common_status;
    logic clk = 1'b0, rst_n = 1'b0, busy = 1'b0, clr = 1'b0, pwrgd = 1'b0;
    logic aux = 1'b0, areq = 1'b0, share = 1'b0, shr_run = 1'b1, wp = 1'b0;
    logic [1:0] fb = 2'h3, cg = 2'h3, onf = 2'h0, az = 2'h0, ao = 2'h0;
    logic [1:0] fpl = 2'h0, gpl = 2'h0, on_cmd = 2'h0, offp = 2'h0;
    logic [1:0] vin = 2'h0, sc = 2'h0, vo = 2'h0;
    logic cv, pg, rv, nack, bflag, a_oe;
    logic [7:0] code;
    logic [15:0] rdat;
    logic [16:0] exq[$];
    logic [31:0] seed = 32'h0001_0E64;
    int fail_count = 0, n_tests = 0;
    wire apad = ~a_oe;
    always #2.5 clk = ~clk;
    always @(negedge clk) if (shr_run) share <= ~share;
    smbus_host_model i_smbus_host_model (.i_clk(clk), .o_cmd_valid(cv),
        .o_cmd_code(code), .o_page(pg));
    pad_common_status i_pad_common_status (.I_REF_CLK(clk), .I_RST_N(rst_n),
        .I_CMD_VALID(cv), .I_CMD_CODE(code), .I_PAGE(pg),
        .I_CLEAR_FAULTS(clr), .I_BUSY(busy), .O_RSP_VALID(rv), .O_RSP_HIT(),
        .O_RSP_NACK(nack), .O_RSP_DATA(rdat), .O_BUSY_FLAG(bflag),
        .I_FAULT_BUS_LINE(fb), .I_CHAN_GOOD(cg), .I_ON_OFF_PIN(onf),
        .I_ADDR_SELECT_ZERO(az), .I_ADDR_SELECT_ONE(ao), .I_SHARE_CLK(share),
        .I_WRITE_PROTECT(wp), .I_ALERT_PIN(apad), .I_PWRGD_PULL(pwrgd),
        .I_FAULT_BUS_PULL(fpl), .I_CHAN_GOOD_PULL(gpl),
        .I_AUX_FAULT_PULL(aux), .I_ALERT_REQ(areq), .I_CHAN_ON_CMD(on_cmd),
        .I_OFF_IN_PROGRESS(offp), .I_VIN_OFF_EVT(vin), .O_ALERT_O(),
        .O_ALERT_OE(a_oe));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [1:0] asel(input logic [1:0] s);
        return s[1] ? `ASEL_FLOAT : (s[0] ? `ASEL_HIGH : `ASEL_LOW);
    endfunction
    function automatic logic [16:0] pad_exp();
        return {1'b0, ~pwrgd, ~(areq | (|sc)), ~fpl[0], ~fpl[1],
            ~gpl[1], ~gpl[0], asel(ao), asel(az), onf[1], onf[0],
            fb[0], fb[1], cg[1], cg[0]};
    endfunction
    function automatic logic [16:0] com_exp(input logic sh);
        return {9'h000, ~(areq | (|sc)), ~busy, 4'hF, sh, wp};
    endfunction
    function automatic logic [16:0] ext_exp(input logic p);
        return {14'h0000, sc[p], aux, vo[p]};
    endfunction
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rd_cmd(input logic [7:0] c, input logic p,
        input logic [16:0] e);
        exq.push_back(e);
        i_smbus_host_model.read_cmd(c, p);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (rv === 1'b1) chk({nack, rdat}, exq.pop_front());
    end
    initial begin
        cyc(6000);
        fail_count++;
        stop_test();
    end
    initial begin
        cyc(6);
        rst_n = 1'b1;
        cyc(4);
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            {fb, cg, onf, az, ao, fpl, gpl} = seed[13:0];
            {pwrgd, wp, areq, aux} = seed[17:14];
            cyc(6);
            rd_cmd(`CMD_PAD_LEVEL_SNAPSHOT, seed[18], pad_exp());
            rd_cmd(`CMD_DEVICE_COMMON_STATUS, seed[18], com_exp(1'b0));
            rd_cmd(`CMD_EXTRA_FAULT_STATE_STATUS, seed[18], ext_exp(seed[18]));
        end
        areq = 1'b0;
        rd_cmd(8'h5A, 1'b0, 17'h0_0000);
        $display("test done: random pad levels");
        busy = 1'b1;
        cyc(2);
        rd_cmd(`CMD_PAD_LEVEL_SNAPSHOT, 1'b0, 17'h1_0000);
        rd_cmd(`CMD_DEVICE_COMMON_STATUS, 1'b0, com_exp(1'b0));
        rd_cmd(`CMD_EXTRA_FAULT_STATE_STATUS, 1'b1, 17'h1_0000);
        rd_cmd(8'h5A, 1'b1, 17'h1_0000);
        cyc(2);
        chk({16'h0000, bflag}, 17'h0_0001);
        busy = 1'b0;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(2);
        chk({16'h0000, bflag}, 17'h0_0000);
        $display("test done: busy refusal");
        offp = 2'h1;
        on_cmd = 2'h1;
        cyc(1);
        {on_cmd, offp, sc} = 6'h01;
        cyc(8);
        rd_cmd(`CMD_EXTRA_FAULT_STATE_STATUS, 1'b0, ext_exp(1'b0));
        rd_cmd(`CMD_EXTRA_FAULT_STATE_STATUS, 1'b1, ext_exp(1'b1));
        rd_cmd(`CMD_PAD_LEVEL_SNAPSHOT, 1'b0, pad_exp());
        rd_cmd(`CMD_DEVICE_COMMON_STATUS, 1'b0, com_exp(1'b0));
        clr = 1'b1;
        cyc(1);
        {clr, sc, vin} = 5'h02;
        cyc(1);
        {vin, vo} = 4'h2;
        cyc(3);
        rd_cmd(`CMD_EXTRA_FAULT_STATE_STATUS, 1'b0, ext_exp(1'b0));
        rd_cmd(`CMD_EXTRA_FAULT_STATE_STATUS, 1'b1, ext_exp(1'b1));
        on_cmd = 2'h2;
        cyc(1);
        {on_cmd, vo} = 4'h0;
        cyc(2);
        rd_cmd(`CMD_EXTRA_FAULT_STATE_STATUS, 1'b1, ext_exp(1'b1));
        $display("test done: sticky flags");
        shr_run = 1'b0;
        cyc(1);
        share = 1'b0;
        cyc(2010);
        rd_cmd(`CMD_DEVICE_COMMON_STATUS, 1'b0, com_exp(1'b1));
        cyc(4);
        $display("test done: share clock idle");
        stop_test();
    end
endmodule
